// File: hdl/reset_boot_sequencer.sv
// Notes on behaviour
// R1 - warm reset input is active low, high means run.
// R2 - the board holds warm reset low at least 30 device clock cycles.
// R3 - while warm reset is low all non-test pins float with pulls on.
// R4 - warm reset resets all modules except test, ethernet switch, plls and clock setup.
// R5 - on warm release the main core and plain modules leave reset, excluded logic keeps state.
// R6 - after warm release with strap 11 low the reset-out watchdog is asserted for a count.
// R7 - the board holds power-on reset low until clocks settle plus two more cycles.
// R8 - while power-on reset is low everything resets and all non-emulation pins float.
// R9 - while power-on reset is low clocks propagate with every pll in bypass.
// R10 - on power-on reset release all sixteen strap levels are captured.
// R11 - after power-on release with strap 11 low the reset-out watchdog pulses briefly.
// R12 - after either release peripherals take defaults and the core fetches from boot rom.
// R13 - five select straps pick an ordered list tried in turn until one succeeds.
// R14 - the four documented strap patterns map to their four-entry source lists.
// R15 - the board holds reserved strap positions low.
// R16 - the warm reset-out pulse length is a parameter in device clock cycles.
`timescale 1ns/1ps
`default_nettype none
module reset_boot_sequencer
  import rst_boot_pkg::*;
#(
  parameter int WD_CYC = WD_PULSE_CYC
)(
  // clock and control
  input  wire logic                     clk_i,
  input  wire logic                     srst_i,
  input  wire logic                     ce_i,
  // board reset pins
  input  wire logic                     warm_reset_n_i,
  input  wire logic                     power_on_reset_n_i,
  // straps
  input  wire logic [STRAP_W-1:0]       boot_strap_pins_i,
  // boot attempt feedback from boot rom
  input  wire logic                     boot_done_i,
  input  wire logic                     boot_fail_i,
  // reset distribution
  output logic                          core_rst_o,
  output logic                          test_rst_o,
  output logic                          switch_rst_o,
  output logic                          clk_cfg_rst_o,
  output logic                          pll_bypass_o,
  output logic                          pins_hiz_o,
  output logic                          test_pins_hiz_o,
  output logic                          periph_defaults_o,
  output logic                          rom_fetch_o,
  output logic                          reset_out_watchdog_o,
  // boot status
  output logic [STRAP_W-1:0]            strap_latched_o,
  output rst_boot_pkg::boot_src_e       boot_src_o,
  output logic [1:0]                    boot_idx_o,
  output logic                          boot_active_o,
  output logic                          boot_ok_o,
  output logic                          boot_exhausted_o
);
  import rst_boot_pkg::*;

  localparam int       COLD_GRP_N = 5;

  seq_state_e          state_reg, state_next;
  cnt_t                wd_cnt_reg;
  cnt_t                wd_cnt_next;
  logic                por_q_reg;
  logic [STRAP_W-1:0]  strap_reg;
  logic [1:0]          idx_reg;
  logic [1:0]          idx_next;
  logic                cold_reg;
  boot_src_e           src_w;
  wire logic [COLD_GRP_N-1:0] cold_grp;

  boot_if bi ();
  assign bi.sel = strap_reg[SEL_LSB +: SEL_W];  // R13
  assign bi.idx = idx_reg;
  assign src_w  = bi.src;

  boot_order_table u_table (
    .bi (bi.tbl)
  );

  wire logic por_low  = ~power_on_reset_n_i;  // R1
  wire logic warm_low = ~warm_reset_n_i;      // R1
  wire logic por_rise = power_on_reset_n_i & ~por_q_reg;
  wire logic wd_armed = ~strap_reg[WD_STRAP_BIT];

  // power-on pin history for its rising edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      por_q_reg <= 1'b0;
    end else if (ce_i) begin
      por_q_reg <= power_on_reset_n_i;
    end
  end

  // strap capture only on power-on release
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      strap_reg <= STRAP_RST;
    end else if (ce_i && por_rise) begin
      strap_reg <= boot_strap_pins_i;  // R10
    end
  end

  // remembers whether the last reset was cold, for pulse length
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cold_reg <= 1'b1;
    end else if (ce_i) begin
      if (por_low) begin
        cold_reg <= 1'b1;
      end else if (warm_low) begin
        cold_reg <= 1'b0;
      end
    end
  end

  // strap 11 seen in the same cycle as capture
  function automatic logic wd_armed_next();
    return por_rise ? ~boot_strap_pins_i[WD_STRAP_BIT] : wd_armed;
  endfunction : wd_armed_next

  // last entry of the ordered list
  function automatic logic at_last_entry(input logic [1:0] i);
    return i == 2'(LIST_LEN - 1);
  endfunction : at_last_entry

  // states in which the core stays in reset
  function automatic logic held_in_reset(input seq_state_e s);
    return s == ST_COLD || s == ST_WARM;
  endfunction : held_in_reset

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_COLD: begin
        if (!por_low && !warm_low) begin
          state_next = wd_armed_next() ? ST_PULSE : ST_BOOT;  // R11
        end else if (!por_low) begin
          state_next = ST_WARM;
        end
      end
      ST_WARM: begin
        if (!warm_low) begin
          state_next = wd_armed ? ST_PULSE : ST_BOOT;  // R6
        end
      end
      ST_PULSE: begin
        if (wd_cnt_reg == cnt_t'(1)) begin
          state_next = ST_BOOT;
        end
      end
      ST_BOOT: begin
        if (boot_done_i) begin
          state_next = ST_RUN;
        end else if (boot_fail_i && at_last_entry(idx_reg)) begin
          state_next = ST_FAIL;  // R13
        end
      end
      ST_RUN:  state_next = ST_RUN;
      ST_FAIL: state_next = ST_FAIL;
      default: state_next = ST_COLD;
    endcase
    if (por_low) begin
      state_next = ST_COLD;  // R8
    end else if (warm_low) begin
      state_next = ST_WARM;  // R4
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= ST_COLD;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // reset-out watchdog length: brief after cold, parameter after warm
  always_comb begin
    wd_cnt_next = wd_cnt_reg;
    if (state_reg != ST_PULSE && state_next == ST_PULSE) begin
      wd_cnt_next = cold_reg ? cnt_t'(POR_MIN_CYC) : cnt_t'(WD_CYC);  // R16
    end else if (state_reg == ST_PULSE && wd_cnt_reg != '0) begin
      wd_cnt_next = wd_cnt_reg - cnt_t'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wd_cnt_reg <= '0;
    end else if (ce_i) begin
      wd_cnt_reg <= wd_cnt_next;
    end
  end

  // fallback through the ordered list
  always_comb begin
    idx_next = idx_reg;
    if (state_reg != ST_BOOT) begin
      idx_next = '0;
    end else if (boot_fail_i && !boot_done_i && !at_last_entry(idx_reg)) begin
      idx_next = idx_reg + 2'(1);  // R13
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      idx_reg <= '0;
    end else if (ce_i) begin
      idx_reg <= idx_next;
    end
  end

  // cold-only resets share one shape
  generate
    for (genvar g = 0; g < COLD_GRP_N; g++) begin : g_cold_grp
      logic q_reg;
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          q_reg <= 1'b1;
        end else if (ce_i) begin
          q_reg <= por_low;  // R8 R9
        end
      end
      assign cold_grp[g] = q_reg;
    end
  endgenerate

  assign test_rst_o      = cold_grp[0];  // R8
  assign switch_rst_o    = cold_grp[1];  // R4
  assign clk_cfg_rst_o   = cold_grp[2];  // R4
  assign pll_bypass_o    = cold_grp[3];  // R9
  assign test_pins_hiz_o = cold_grp[4];  // R8

  // core reset, reached by warm reset too
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      core_rst_o <= 1'b1;
    end else if (ce_i) begin
      core_rst_o <= por_low | warm_low | held_in_reset(state_next);  // R4 R5
    end
  end

  // pins float through either reset and the reset-out pulse
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pins_hiz_o <= 1'b1;
    end else if (ce_i) begin
      pins_hiz_o <= por_low | warm_low | held_in_reset(state_next)
                    | state_next == ST_PULSE;  // R3 R8
    end
  end

  // boot rom phase
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      periph_defaults_o <= 1'b1;
      rom_fetch_o       <= 1'b0;
    end else if (ce_i) begin
      periph_defaults_o <= state_next != ST_RUN;  // R12
      rom_fetch_o       <= state_next == ST_BOOT;  // R12
    end
  end

  // reset-out watchdog output
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reset_out_watchdog_o <= 1'b0;
    end else if (ce_i) begin
      reset_out_watchdog_o <= state_next == ST_PULSE;  // R6 R11
    end
  end

  // captured straps as seen by later logic
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      strap_latched_o <= STRAP_RST;
    end else if (ce_i) begin
      strap_latched_o <= por_rise ? boot_strap_pins_i : strap_reg;  // R10
    end
  end

  // list position and the source it names
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      boot_src_o <= SRC_NONE;
      boot_idx_o <= '0;
    end else if (ce_i) begin
      boot_src_o <= src_w;  // R13
      boot_idx_o <= idx_reg;
    end
  end

  // boot progress flags
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      boot_active_o    <= 1'b0;
      boot_ok_o        <= 1'b0;
      boot_exhausted_o <= 1'b0;
    end else if (ce_i) begin
      boot_active_o    <= state_next == ST_BOOT;
      boot_ok_o        <= state_next == ST_RUN;
      boot_exhausted_o <= state_next == ST_FAIL;
    end
  end

endmodule : reset_boot_sequencer
`default_nettype wire

// File: hdl/rst_boot_pkg.sv
package rst_boot_pkg;

  localparam int          STRAP_W        = 16;
  localparam int          SEL_W          = 5;
  localparam int          SRC_W          = 3;
  localparam int          LIST_LEN       = 4;
  localparam int          WD_STRAP_BIT   = 11;
  localparam int          SEL_LSB        = 1;

  localparam int          CLK_HZ         = 20_000_000;
  localparam int          WARM_MIN_CYC   = 30;
  localparam int          POR_MIN_CYC    = 2;
  localparam int          WD_PULSE_CYC   = 8;
  localparam int          CNT_W          = 16;

  localparam logic [STRAP_W-1:0] STRAP_RST = 16'h0000;

  localparam logic [SEL_W-1:0] SEL_NAND_FIRST = 5'h12;
  localparam logic [SEL_W-1:0] SEL_UART_FIRST = 5'h01;
  localparam logic [SEL_W-1:0] SEL_MMC_FIRST  = 5'h17;
  localparam logic [SEL_W-1:0] SEL_ETH_FIRST  = 5'h04;

  typedef enum logic [SRC_W-1:0] {
    SRC_NONE  = 3'h0,
    SRC_NAND  = 3'h1,
    SRC_NANDI = 3'h2,
    SRC_SPI   = 3'h3,
    SRC_UART  = 3'h4,
    SRC_XIP   = 3'h5,
    SRC_MMC   = 3'h6,
    SRC_ETH   = 3'h7
  } boot_src_e;

  typedef enum logic [2:0] {
    ST_COLD   = 3'b000,
    ST_PULSE  = 3'b001,
    ST_BOOT   = 3'b011,
    ST_RUN    = 3'b010,
    ST_WARM   = 3'b101,
    ST_FAIL   = 3'b111
  } seq_state_e;

  typedef logic [CNT_W-1:0] cnt_t;

endpackage : rst_boot_pkg

// File: hdl/boot_if.sv
`timescale 1ns/1ps
`default_nettype none
interface boot_if;
  import rst_boot_pkg::*;
  logic [SEL_W-1:0] sel;
  logic [1:0]       idx;
  boot_src_e        src;
  modport seq (output sel, output idx, input src);
  modport tbl (input sel, input idx, output src);
endinterface : boot_if
`default_nettype wire

// File: hdl/boot_order_table.sv
`timescale 1ns/1ps
`default_nettype none
module boot_order_table
  import rst_boot_pkg::*;
(
  boot_if.tbl bi
);

  // ordered source list per strap pattern
  function automatic boot_src_e lookup(input logic [SEL_W-1:0] s, input logic [1:0] i);
    boot_src_e l [LIST_LEN];
    l = '{SRC_NONE, SRC_NONE, SRC_NONE, SRC_NONE};
    case (s)
      SEL_NAND_FIRST: l = '{SRC_NAND, SRC_NANDI, SRC_SPI, SRC_UART};  // R14
      SEL_UART_FIRST: l = '{SRC_UART, SRC_XIP, SRC_MMC, SRC_SPI};     // R14
      SEL_MMC_FIRST:  l = '{SRC_MMC, SRC_SPI, SRC_UART, SRC_ETH};     // R14
      SEL_ETH_FIRST:  l = '{SRC_ETH, SRC_SPI, SRC_NAND, SRC_NANDI};   // R14
      default:        l = '{SRC_NONE, SRC_NONE, SRC_NONE, SRC_NONE};
    endcase
    return l[i];
  endfunction : lookup

  assign bi.src = lookup(bi.sel, bi.idx);

endmodule : boot_order_table
`default_nettype wire

// File: tb/boot_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module boot_seq_checker
  import rst_boot_pkg::*;
#(
  parameter int WD_CYC = WD_PULSE_CYC
)(
  // inputs
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        warm_reset_n_i,
  input wire logic        power_on_reset_n_i,
  input wire logic [15:0] boot_strap_pins_i,
  input wire logic        boot_done_i,
  input wire logic        boot_fail_i,
  // outputs
  input wire logic        core_rst_o,
  input wire logic        test_rst_o,
  input wire logic        switch_rst_o,
  input wire logic        clk_cfg_rst_o,
  input wire logic        pll_bypass_o,
  input wire logic        test_pins_hiz_o,
  input wire logic        pins_hiz_o,
  input wire logic        reset_out_watchdog_o,
  input wire logic [15:0] strap_latched_o,
  input wire logic [1:0]  boot_idx_o,
  input wire logic        boot_active_o,
  input wire logic        boot_ok_o,
  input wire logic        boot_exhausted_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // pulse length so far, and whether a warm reset came last
  cnt_t wd_len;
  logic warm_src;
  always_ff @(posedge clk_i) begin
    if (srst_i || !reset_out_watchdog_o) wd_len <= 16'h0000;
    else wd_len <= wd_len + 16'h0001;
  end
  always_ff @(posedge clk_i) begin
    if (srst_i || !power_on_reset_n_i) warm_src <= 1'b0;
    else if (!warm_reset_n_i) warm_src <= 1'b1;
  end
  cold_all_a: assert property (
    !power_on_reset_n_i |=> test_rst_o && switch_rst_o && core_rst_o && pll_bypass_o
    && clk_cfg_rst_o && pins_hiz_o && test_pins_hiz_o)
    else $error("cold reset not spread");
  warm_hold_a: assert property (
    power_on_reset_n_i && $past(power_on_reset_n_i) && !warm_reset_n_i
    |=> core_rst_o && pins_hiz_o && !switch_rst_o && !pll_bypass_o
    && !test_rst_o && !clk_cfg_rst_o) else $error("warm reset");
  warm_rise_a: assert property (
    $rose(warm_reset_n_i) && power_on_reset_n_i |-> ##[1:2] !core_rst_o)
    else $error("core kept in reset");
  strap_cap_a: assert property (
    $rose(power_on_reset_n_i) |-> ##[1:2] strap_latched_o == boot_strap_pins_i)
    else $error("straps not captured");
  wd_len_a: assert property (
    $fell(reset_out_watchdog_o) |-> wd_len == (warm_src ? cnt_t'(WD_CYC) : 16'h0002))
    else $error("reset-out pulse length");
  fail_step_a: assert property (
    boot_active_o && boot_fail_i && !boot_done_i && boot_idx_o != 2'h3
    |=> ##1 boot_idx_o == $past(boot_idx_o, 2) + 2'h1) else $error("fallback step");
  exhaust_a: assert property (
    boot_active_o && boot_fail_i && !boot_done_i && boot_idx_o == 2'h3 |=> boot_exhausted_o)
    else $error("list not exhausted");
  boot_ok_a: assert property (
    boot_active_o && boot_done_i |-> ##[1:2] boot_ok_o) else $error("boot not done");
endmodule : boot_seq_checker
`default_nettype wire

// File: tb/board_model.sv
`timescale 1ns/1ps
`default_nettype none
module board_model
  import rst_boot_pkg::*;
(
  input  wire logic        clk_i,
  output logic             warm_n_o,
  output logic             por_n_o,
  output logic [15:0]      strap_o
);
  initial begin
    warm_n_o = 1'b1;
    por_n_o = 1'b0;
    strap_o = STRAP_RST;
  end
  task automatic cold(input logic [SEL_W-1:0] sel, input logic wd_off);
    @(posedge clk_i) #5;
    por_n_o = 1'b0;
    strap_o = {4'h0, wd_off, 5'h00, sel, 1'b0};
    repeat (4) @(posedge clk_i);
    #5 por_n_o = 1'b1;
  endtask : cold
  task automatic warm();
    @(posedge clk_i) #5 warm_n_o = 1'b0;
    repeat (WARM_MIN_CYC) @(posedge clk_i);
    #5 warm_n_o = 1'b1;
  endtask : warm
endmodule : board_model
`default_nettype wire

// File: tb/reset_boot_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module reset_boot_sequencer_test
  import rst_boot_pkg::*;
;
  localparam int WD_C = 5;
  logic clk_i, srst_i, done_i, fail_i, warm_n, por_n;
  logic core_rst, sw_rst, bypass, hiz, pdef, rom, wd, act, ok, exh;
  logic [15:0] strap, latched;
  logic [SEL_W-1:0] sels [5];
  logic [1:0] idx;
  boot_src_e src;
  int err_total, comparisons;
  reset_boot_sequencer #(.WD_CYC(WD_C)) u_dut (.clk_i, .srst_i, .ce_i(1'b1),
    .warm_reset_n_i(warm_n), .power_on_reset_n_i(por_n), .boot_strap_pins_i(strap),
    .boot_done_i(done_i), .boot_fail_i(fail_i), .core_rst_o(core_rst), .test_rst_o(),
    .switch_rst_o(sw_rst), .clk_cfg_rst_o(), .pll_bypass_o(bypass), .pins_hiz_o(hiz),
    .test_pins_hiz_o(), .periph_defaults_o(pdef), .rom_fetch_o(rom),
    .reset_out_watchdog_o(wd), .strap_latched_o(latched), .boot_src_o(src),
    .boot_idx_o(idx), .boot_active_o(act), .boot_ok_o(ok), .boot_exhausted_o(exh));
  board_model u_board (.clk_i, .warm_n_o(warm_n), .por_n_o(por_n), .strap_o(strap));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  function automatic boot_src_e exp_src(input logic [SEL_W-1:0] s, input int i);
    boot_src_e t [4][4] = '{'{SRC_NAND, SRC_NANDI, SRC_SPI, SRC_UART},
      '{SRC_UART, SRC_XIP, SRC_MMC, SRC_SPI}, '{SRC_MMC, SRC_SPI, SRC_UART, SRC_ETH},
      '{SRC_ETH, SRC_SPI, SRC_NAND, SRC_NANDI}};
    for (int k = 0; k < 4; k++) if (s == sels[k]) return t[k][i];
    return SRC_NONE;
  endfunction : exp_src
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic run_boot(output int n);
    n = 0;
    for (int k = 0; k < 200 && act !== 1'b1; k++) begin
      @(posedge clk_i) #5;
      n += int'(wd === 1'b1);
    end
    chk("boot_active", 16'h0001, 16'(act));
    if (act !== 1'b1) end_sim();
  endtask : run_boot
  initial begin
    int n, f;
    logic a;
    {srst_i, done_i, fail_i} = 3'b100;
    err_total = 0;
    comparisons = 0;
    sels = '{SEL_NAND_FIRST, SEL_UART_FIRST, SEL_MMC_FIRST, SEL_ETH_FIRST, 5'h1F};
    n = $urandom(47);
    repeat (6) @(posedge clk_i);
    #5 srst_i = 1'b0;
    for (int t = 0; t < 5; t++) begin
      a = (t == 1) || (t > 1 && $urandom % 2 == 1);
      f = (t == 1) ? 4 : $urandom % 5;
      u_board.cold(sels[t], a);
      run_boot(n);
      chk("latched", strap, latched);
      chk("cold_pulse", a ? 16'h0000 : 16'h0002, 16'(n));
      for (int i = 0; i <= f; i++) begin
        repeat (2) @(posedge clk_i);
        #5;
        if (i < 4) chk("src", 16'(exp_src(sels[t], i)), 16'(src));
        if (i < 4) chk("idx", 16'(i), 16'(idx));
        fail_i = (i < f);
        done_i = (i == f) && (f < 4);
        @(posedge clk_i) #5;
        {fail_i, done_i} = 2'b00;
      end
      repeat (2) @(posedge clk_i);
      #5;
      chk("exhausted", 16'(f == 4), 16'(exh));
      chk("defaults", 16'(f == 4), 16'(pdef));
      chk("boot_ok", 16'(f < 4), 16'(ok));
      $display("cold boot test %0d done", t);
    end
    u_board.cold(SEL_MMC_FIRST, 1'b0);
    run_boot(n);
    fork
      u_board.warm();
      begin
        repeat (9) @(posedge clk_i);
        #5;
        chk("warm_core", 16'h0001, 16'(core_rst));
        chk("warm_pins", 16'h0001, 16'(hiz));
        chk("warm_kept", 16'h0000, 16'({sw_rst, bypass}));
      end
    join
    run_boot(n);
    chk("warm_pulse", 16'(WD_C), 16'(n));
    chk("core_free", 16'h0000, 16'(core_rst));
    chk("rom_fetch", 16'h0001, 16'(rom));
    repeat (2) @(posedge clk_i);
    #5;
    chk("warm_src", 16'(SRC_MMC), 16'(src));
    $display("warm reset test done");
    end_sim();
  end
endmodule : reset_boot_sequencer_test
bind reset_boot_sequencer boot_seq_checker #(.WD_CYC(WD_CYC)) u_chk (.clk_i, .srst_i,
  .warm_reset_n_i, .power_on_reset_n_i, .boot_strap_pins_i, .boot_done_i, .boot_fail_i,
  .core_rst_o, .test_rst_o, .switch_rst_o, .clk_cfg_rst_o, .pll_bypass_o, .test_pins_hiz_o,
  .pins_hiz_o, .strap_latched_o,
  .reset_out_watchdog_o, .boot_idx_o, .boot_active_o, .boot_ok_o, .boot_exhausted_o);
`default_nettype wire
